// *** src/port_irq_pkg.sv ***
// package: register map, timing and carrier types of the port edge-interrupt unit
package port_irq_pkg;

	// ------------------------------------------------------------
	// register map (index on the register port)
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_FLAGS = 4'h0;    // port_irq_flags, read only
	localparam logic [3:0] ADDR_CLEAR = 4'h1;    // write one to clear a flag, write only
	localparam logic [3:0] ADDR_ENABLES = 4'h2;  // port_irq_enables
	localparam logic [3:0] ADDR_POLARITY = 4'h3; // edge_polarity_select, 1 = rising
	localparam logic [3:0] ADDR_DIEN = 4'h4;     // digital_input_enable
	localparam logic [3:0] ADDR_DOUT = 4'h5;     // output data
	localparam logic [3:0] ADDR_DIR = 4'h6;      // direction, 1 = output
	localparam logic [3:0] ADDR_PINS = 4'h7;     // digital input level seen by the filters

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic [7:0] RST_ENABLES = 8'h00;
	localparam logic [7:0] RST_POLARITY = 8'h00;
	localparam logic [7:0] RST_DIEN = 8'h00;
	localparam logic [7:0] RST_DOUT = 8'h00;
	localparam logic [7:0] RST_DIR = 8'h00;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int RC_PERIOD_NS = 2500;     // stop-mode oscillator period
	localparam int STOP_IGNORE_NS = 3200;   // stop-mode pulses up to this are dropped
	localparam int STOP_ACCEPT_NS = 10000;  // stop-mode pulses from this on are taken
	localparam int RC_TICK_CYC = RC_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [2:0] FILTER_SAMPLES = 3'h4; // consecutive samples per level
	localparam logic [2:0] CNT_SETTLED = 3'h5;    // saturation, beyond the window
	localparam logic [6:0] RC_LAST = 7'(RC_TICK_CYC - 1);

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;

	typedef struct packed {
		logic stop;        // cpu is in stop mode
		logic wait_mode;   // cpu is in wait mode
		logic analog_en;   // analog module owns the port
	} mode_t;

endpackage

// *** src/port_edge_irq.sv ***
// eight-pin port with filtered edge interrupts, flags, enables and stop wake-up
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module port_edge_irq
(
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_nrst,
	// register port
	input wire port_irq_pkg::bus_req_t i_bus,
	output logic [7:0] o_rdata,
	// cpu mode and analog ownership
	input wire port_irq_pkg::mode_t i_mode,
	// port pins
	input wire logic [7:0] i_pin,
	output logic [7:0] o_pin,
	output logic [7:0] o_pin_oe,
	// interrupt and wake-up
	output logic o_irq,
	output logic o_wake
);
	import port_irq_pkg::*;

	// ------------------------------------------------------------
	// registers and state
	// ------------------------------------------------------------
	logic [7:0] pin_irq_flag;
	logic [7:0] pin_irq_enable;
	logic [7:0] edge_polarity_select;
	logic [7:0] digital_input_enable;
	logic [7:0] dout;
	logic [7:0] dir;
	logic [7:0] pin_meta;
	logic [7:0] pin_sync;
	logic [7:0] prev_lvl;
	logic [7:0] armed;
	logic [2:0] cnt [8];
	logic [6:0] rc_div;
	logic [7:0] din;
	logic [7:0] lvl;
	logic [7:0] edge_hit;
	logic [7:0] clr_mask;
	logic [2:0] next_cnt [8];
	logic sample_en;
	logic rc_need;
	logic rc_tick;

	// active level of a pin as seen by the edge logic
	function automatic logic active_level(input logic d, input logic pol);
		active_level = pol ? d : ~d;
	endfunction

	// ------------------------------------------------------------
	// pin input path
	// ------------------------------------------------------------
	// two stages, the first one read by the second alone
	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			pin_meta <= 8'h00;
			pin_sync <= 8'h00;
		end
		else
		begin
			pin_meta <= i_pin;
			pin_sync <= pin_meta;
		end
	end

	// digital level per pin; outputs watch their own driven value
	always_comb
	begin
		for (int k = 0; k < 8; k++)
		begin
			if (i_mode.analog_en)
				din[k] = 1'b1;
			else if (dir[k])
				din[k] = dout[k];
			else
				din[k] = digital_input_enable[k] ? pin_sync[k] : 1'b1;
			lvl[k] = active_level(din[k], edge_polarity_select[k]);
		end
	end

	// ------------------------------------------------------------
	// sample clock: bus clock in run/wait, gated rc tick in stop
	// ------------------------------------------------------------
	// an enabled, unflagged pin still needs samples while its count is open or its level moved;
	// a settled idle pin lets the oscillator stop to save current
	always_comb
	begin
		rc_need = 1'b0;
		for (int k = 0; k < 8; k++)
			if (pin_irq_enable[k] && !pin_irq_flag[k]
				&& (cnt[k] <= FILTER_SAMPLES || lvl[k] != prev_lvl[k]))
				rc_need = 1'b1;
	end

	// rc oscillator modelled as a divider that only counts while needed
	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
			rc_div <= 7'h00;
		else if (!(i_mode.stop && rc_need))
			rc_div <= 7'h00;
		else if (rc_div == RC_LAST)
			rc_div <= 7'h00;
		else
			rc_div <= rc_div + 7'h01;
	end

	assign rc_tick = i_mode.stop && rc_need && rc_div == RC_LAST;
	assign sample_en = i_mode.stop ? rc_tick : 1'b1;

	// ------------------------------------------------------------
	// glitch filter
	// ------------------------------------------------------------
	// count consecutive equal samples, saturating past the window
	always_comb
	begin
		for (int k = 0; k < 8; k++)
		begin
			if (lvl[k] != prev_lvl[k])
				next_cnt[k] = 3'h1;
			else if (cnt[k] < CNT_SETTLED)
				next_cnt[k] = cnt[k] + 3'h1;
			else
				next_cnt[k] = cnt[k];
			// four active samples after an armed passive run make an edge
			edge_hit[k] = sample_en && lvl[k] && armed[k]
				&& next_cnt[k] == FILTER_SAMPLES;
		end
	end

	// sample history per pin
	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			prev_lvl <= 8'h00;
			for (int k = 0; k < 8; k++)
				cnt[k] <= 3'h0;
		end
		else if (sample_en)
		begin
			prev_lvl <= lvl;
			for (int k = 0; k < 8; k++)
				cnt[k] <= next_cnt[k];
		end
	end

	// arming survives uncertain bounces, so an indirect edge still counts
	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
			armed <= 8'h00;
		else if (sample_en)
		begin
			for (int k = 0; k < 8; k++)
			begin
				if (edge_hit[k])
					armed[k] <= 1'b0;
				else if (!lvl[k] && next_cnt[k] == FILTER_SAMPLES)
					armed[k] <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// flags: set wins over a clear in the same cycle
	// ------------------------------------------------------------
	assign clr_mask = (i_bus.wr && i_bus.addr == ADDR_CLEAR) ? i_bus.wdata : 8'h00;

	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
			pin_irq_flag <= RST_FLAGS;
		else
			pin_irq_flag <= (pin_irq_flag & ~clr_mask) | edge_hit;
	end

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			pin_irq_enable <= RST_ENABLES;
			edge_polarity_select <= RST_POLARITY;
			digital_input_enable <= RST_DIEN;
			dout <= RST_DOUT;
			dir <= RST_DIR;
		end
		else if (i_bus.wr)
		begin
			case (i_bus.addr)
				ADDR_ENABLES: pin_irq_enable <= i_bus.wdata;
				ADDR_POLARITY: edge_polarity_select <= i_bus.wdata;
				ADDR_DIEN: digital_input_enable <= i_bus.wdata;
				ADDR_DOUT: dout <= i_bus.wdata;
				ADDR_DIR: dir <= i_bus.wdata;
				default: ;
			endcase
		end
	end

	// read data stands one cycle after the strobe; unmapped reads zero
	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
			o_rdata <= 8'h00;
		else if (i_bus.rd)
		begin
			case (i_bus.addr)
				ADDR_FLAGS: o_rdata <= pin_irq_flag;
				ADDR_ENABLES: o_rdata <= pin_irq_enable;
				ADDR_POLARITY: o_rdata <= edge_polarity_select;
				ADDR_DIEN: o_rdata <= digital_input_enable;
				ADDR_DOUT: o_rdata <= dout;
				ADDR_DIR: o_rdata <= dir;
				ADDR_PINS: o_rdata <= din;
				default: o_rdata <= 8'h00;
			endcase
		end
		else
			o_rdata <= 8'h00;
	end

	// ------------------------------------------------------------
	// pins, request and wake-up
	// ------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_pin <= 8'h00;
			o_pin_oe <= 8'h00;
		end
		else
		begin
			o_pin <= dout;
			o_pin_oe <= i_mode.analog_en ? 8'h00 : dir;
		end
	end

	// one shared request for all eight pins
	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
			o_irq <= 1'b0;
		else
			o_irq <= |(pin_irq_flag & pin_irq_enable);
	end

	// in stop a moving enabled pin wakes at once, before the slow filter
	// has decided; the flag itself still waits for a valid edge
	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
			o_wake <= 1'b0;
		else
			o_wake <= (i_mode.stop || i_mode.wait_mode)
				&& (|(pin_irq_flag & pin_irq_enable)
				|| (i_mode.stop && |(pin_irq_enable & ~pin_irq_flag
				& (lvl ^ prev_lvl))));
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	property p_irq_follows;
		@(posedge i_mclk) disable iff (!i_nrst)
		1'b1 |=> o_irq == |($past(pin_irq_flag) & $past(pin_irq_enable));
	endproperty
	a_irq_follows: assert property (p_irq_follows)
		else $error("request does not follow flag and enable");

	property p_flag_sticky;
		@(posedge i_mclk) disable iff (!i_nrst)
		1'b1 |=> (($past(pin_irq_flag) & ~$past(clr_mask)) & ~pin_irq_flag) == 8'h00;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky)
		else $error("flag dropped without a clear");

	property p_edge_sets;
		@(posedge i_mclk) disable iff (!i_nrst)
		|edge_hit |=> (pin_irq_flag & $past(edge_hit)) == $past(edge_hit);
	endproperty
	a_edge_sets: assert property (p_edge_sets)
		else $error("valid edge did not set its flag");

	property p_four_active;
		@(posedge i_mclk) disable iff (!i_nrst)
		(edge_hit[0] && !i_mode.stop && !$past(i_mode.stop) && !$past(i_mode.stop, 2)
			&& !$past(i_mode.stop, 3))
			|-> lvl[0] && $past(lvl[0]) && $past(lvl[0], 2) && $past(lvl[0], 3);
	endproperty
	a_four_active: assert property (p_four_active)
		else $error("edge taken from fewer than four active samples");

	property p_armed_first;
		@(posedge i_mclk) disable iff (!i_nrst)
		edge_hit[0] |-> armed[0] ##1 !armed[0];
	endproperty
	a_armed_first: assert property (p_armed_first)
		else $error("edge without a passive run before it");

	property p_rc_gated;
		@(posedge i_mclk) disable iff (!i_nrst)
		(!i_mode.stop || !rc_need) |=> rc_div == 7'h00;
	endproperty
	a_rc_gated: assert property (p_rc_gated)
		else $error("rc oscillator ran while not needed");

	property p_run_sampling;
		@(posedge i_mclk) disable iff (!i_nrst)
		!i_mode.stop |=> prev_lvl == $past(lvl);
	endproperty
	a_run_sampling: assert property (p_run_sampling)
		else $error("filter missed a bus clock sample");

	property p_analog_off;
		@(posedge i_mclk) disable iff (!i_nrst)
		i_mode.analog_en |=> o_pin_oe == 8'h00;
	endproperty
	a_analog_off: assert property (p_analog_off)
		else $error("output driven while analog owns the port");

	property p_wake;
		@(posedge i_mclk) disable iff (!i_nrst)
		(i_mode.wait_mode && |(pin_irq_flag & pin_irq_enable)) |=> o_wake;
	endproperty
	a_wake: assert property (p_wake)
		else $error("pending request did not wake the cpu");

	property p_read_flags;
		@(posedge i_mclk) disable iff (!i_nrst)
		(i_bus.rd && i_bus.addr == ADDR_FLAGS) |=> o_rdata == $past(pin_irq_flag);
	endproperty
	a_read_flags: assert property (p_read_flags)
		else $error("flag read returned the wrong value");

	c_run_edge: cover property (@(posedge i_mclk) disable iff (!i_nrst)
		!i_mode.stop && |edge_hit);
	c_stop_edge: cover property (@(posedge i_mclk) disable iff (!i_nrst)
		i_mode.stop && |edge_hit);
	c_stop_wake: cover property (@(posedge i_mclk) disable iff (!i_nrst)
		i_mode.stop && o_wake);
	c_set_and_clear: cover property (@(posedge i_mclk) disable iff (!i_nrst)
		|(edge_hit & clr_mask));

endmodule

// *** test/pin_driver.sv ***
// partner model: external drivers standing on the eight port pins
`timescale 1ns/1ps
module pin_driver
(
	// clock
	input wire logic i_mclk,
	// device side of the pins
	input wire logic [7:0] i_dev_out,
	input wire logic [7:0] i_dev_oe,
	// resolved pin levels
	output logic [7:0] o_wire
);
	logic [7:0] ext = 8'hff;

	// a pin the device drives shows its value, any other the external level
	assign o_wire = (i_dev_oe & i_dev_out) | (~i_dev_oe & ext);

	// levels change just after an edge, so every sampler sees whole cycles
	task automatic set_level(input logic [7:0] v);
		@(posedge i_mclk);
		ext <= v;
	endtask

	// invert one pin for len clocks, then restore it
	task automatic pulse(input int idx, input int len);
		logic [7:0] m;
		m = 8'h01 << idx;
		@(posedge i_mclk);
		ext <= ext ^ m;
		repeat (len) @(posedge i_mclk);
		ext <= ext ^ m;
	endtask
endmodule

// *** test/port_edge_irq_test.sv ***
// testbench: edge interrupt port checked against a behavioural filter model
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
	$display("mismatch at %0t: got %h expected %h", $time, a, b); end end
module port_edge_irq_test;
	import port_irq_pkg::*;
	logic mclk;
	logic nrst;
	bus_req_t bus;
	mode_t mode;
	logic [7:0] rdata, pin_out, pin_oe, wire_lvl, v;
	logic irq, wake, act, need, samp;
	logic [7:0] w1, w2;
	int err_count = 0;
	int comparisons = 0;
	int seed = 32'h6c73;
	int cyc = 0;
	int rc;
	logic [7:0] s_en = 8'h00, s_pol = 8'h00, s_dien = 8'h00, s_dir = 8'h00, s_dout = 8'h00, mflags;
	int cnt[8];
	logic lvl[8], armed[8];

	port_edge_irq dut (.i_mclk(mclk), .i_nrst(nrst), .i_bus(bus), .o_rdata(rdata),
		.i_mode(mode), .i_pin(wire_lvl), .o_pin(pin_out), .o_pin_oe(pin_oe),
		.o_irq(irq), .o_wake(wake));
	pin_driver drv (.i_mclk(mclk), .i_dev_out(pin_out), .i_dev_oe(pin_oe), .o_wire(wire_lvl));

	// ------------------------------------------------------------
	// reference model
	// ------------------------------------------------------------
	// active level of one pin; inputs pass two sampling stages first
	function automatic logic act_of(input int i);
		act_of = (mode.analog_en | (s_dir[i] ? s_dout[i] : (~s_dien[i] | w2[i]))) == s_pol[i];
	endfunction

	// the filter works on the active level, so a polarity change counts as a move;
	// in stop the slow sampler only runs while some enabled, unflagged pin needs it
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			mflags = 8'h00;
			rc = 0;
			w1 = 8'h00;
			w2 = 8'h00;
			for (int i = 0; i < 8; i++)
			begin
				cnt[i] = 0;
				lvl[i] = 1'b0;
				armed[i] = 1'b0;
			end
		end
		else
		begin
			need = 1'b0;
			for (int i = 0; i < 8; i++)
				if (s_en[i] && !mflags[i] && (cnt[i] <= 4 || act_of(i) != lvl[i]))
					need = 1'b1;
			samp = !mode.stop;
			if (mode.stop && need)
			begin
				samp = (rc == RC_TICK_CYC - 1);
				rc = samp ? 0 : rc + 1;
			end
			else
				rc = 0;
			if (bus.wr && bus.addr === ADDR_CLEAR)
				mflags = mflags & ~bus.wdata;
			if (samp)
				for (int i = 0; i < 8; i++)
				begin
					act = act_of(i);
					cnt[i] = (act == lvl[i]) ? ((cnt[i] < 5) ? cnt[i] + 1 : 5) : 1;
					lvl[i] = act;
					armed[i] = armed[i] | (!act && cnt[i] >= 4);
					if (act && cnt[i] == 4 && armed[i])
					begin
						mflags[i] = 1'b1;
						armed[i] = 1'b0;
					end
				end
			w2 = w1;
			w1 = wire_lvl;
		end
	end

	// ------------------------------------------------------------
	// bus tasks and run control
	// ------------------------------------------------------------
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		bus.wr <= 1'b0;
		s_en <= (a == ADDR_ENABLES) ? d : s_en;
		s_pol <= (a == ADDR_POLARITY) ? d : s_pol;
		s_dien <= (a == ADDR_DIEN) ? d : s_dien;
		s_dir <= (a == ADDR_DIR) ? d : s_dir;
		s_dout <= (a == ADDR_DOUT) ? d : s_dout;
		#1;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic chk_rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge mclk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		bus.rd <= 1'b0;
		#1;
		`CHK(rdata, exp)
	endtask

	task automatic clk(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic stop_test;
		$display("comparisons %0d, errors %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	// hang guard, far beyond the few thousand cycles the run needs
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_count++;
			stop_test;
		end
	end

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial
	begin
		nrst = 1'b0;
		bus = '0;
		mode = '0;
		repeat (20) @(posedge mclk);
		nrst <= 1'b1;
		clk(2);
		for (int a = 0; a < 16; a++)
			chk_rd(4'(a), (a == 7) ? 8'hff : 8'h00);
		`CHK({irq, wake, pin_oe}, 10'h000)
		for (int a = 2; a < 7; a++)
		begin
			v = 8'($random(seed));
			wr(4'(a), v);
			chk_rd(4'(a), v);
		end
		clk(8);
		wr(ADDR_FLAGS, 8'hff);
		chk_rd(ADDR_FLAGS, mflags);
		// random pulses of 1..8 clocks on random pins, both polarities
		for (int p = 0; p < 2; p++)
		begin
			wr(ADDR_DIR, 8'h00);
			wr(ADDR_DIEN, 8'hff);
			wr(ADDR_POLARITY, p ? 8'hff : 8'h00);
			drv.set_level(p ? 8'h00 : 8'hff);
			clk(10);
			wr(ADDR_CLEAR, 8'hff);
			wr(ADDR_ENABLES, 8'($random(seed)));
			repeat (24)
			begin
				drv.pulse($random(seed) & 7, 1 + ($random(seed) & 7));
				clk(8);
			end
			chk_rd(ADDR_FLAGS, mflags);
			`CHK(irq, |(mflags & s_en))
			wr(ADDR_CLEAR, 8'($random(seed)));
			chk_rd(ADDR_FLAGS, mflags);
			`CHK(irq, |(mflags & s_en))
		end
		// output pin edge; inputs without input enable stay quiet
		wr(ADDR_CLEAR, 8'hff);
		wr(ADDR_DIEN, 8'h00);
		wr(ADDR_POLARITY, 8'h03);
		wr(ADDR_DOUT, 8'h00);
		wr(ADDR_DIR, 8'h01);
		clk(10);
		`CHK({pin_oe, pin_out}, 16'h0100)
		wr(ADDR_CLEAR, 8'hff);
		wr(ADDR_DOUT, 8'h01);
		drv.pulse(1, 6);
		clk(8);
		chk_rd(ADDR_FLAGS, mflags);
		// analog ownership hides the pins
		drv.set_level(8'hff);
		wr(ADDR_DIEN, 8'hff);
		wr(ADDR_POLARITY, 8'h00);
		clk(10);
		wr(ADDR_CLEAR, 8'hff);
		@(posedge mclk) mode.analog_en <= 1'b1;
		drv.pulse(2, 8);
		clk(6);
		`CHK(pin_oe, 8'h00)
		chk_rd(ADDR_PINS, 8'hff);
		chk_rd(ADDR_FLAGS, mflags);
		@(posedge mclk) mode.analog_en <= 1'b0;
		// stop mode: unfiltered wake, slow filter, then wait mode wake
		wr(ADDR_DIR, 8'h00);
		wr(ADDR_ENABLES, 8'hff);
		clk(10);
		wr(ADDR_CLEAR, 8'hff);
		@(posedge mclk) mode.stop <= 1'b1;
		clk(5);
		`CHK(wake, 1'b0)
		drv.set_level(8'hfe);
		clk(3);
		`CHK(wake, 1'b1)
		clk(600);
		drv.set_level(8'hff);
		clk(600);
		drv.pulse(1, 100);
		clk(300);
		chk_rd(ADDR_FLAGS, mflags);
		@(posedge mclk)
		begin
			mode.stop <= 1'b0;
			mode.wait_mode <= 1'b1;
		end
		clk(3);
		`CHK(wake, |(mflags & s_en))
		wr(ADDR_CLEAR, 8'hff);
		clk(3);
		`CHK(wake, 1'b0)
		stop_test;
	end
endmodule
